/* verilog/event_sequencer_trigger_out.sv */
// event point sequencing, pass counts, break delay and trigger outputs
// assumes comparators give one match bit per event point per bus cycle
// and that bus signals come from monitor logic on the same clock
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "evseq_defines.svh"
module event_sequencer_trigger_out (
    input  wire logic        clk,           // system clock, 20 MHz
    input  wire logic        rst_n,         // async reset, active low
    input  wire logic [7:0]  reg_addr,      // register byte offset
    input  wire logic [31:0] reg_wdata,     // register write data
    input  wire logic        reg_wr,        // write strobe
    input  wire logic        reg_rd,        // read strobe
    output logic      [31:0] reg_rdata,     // read data, cycle after strobe
    input  wire logic        user_run_pin,  // user program running, async
    input  wire logic        bus_cycle,     // one pulse per monitored bus cycle
    input  wire logic [31:0] bus_addr,      // monitored access address
    input  wire logic        bus_read,      // access is a read
    input  wire logic        bus_write,     // access is a write
    input  wire logic [3:0]  event_match,   // comparator hit per event point
    output logic      [3:0]  trig_out,      // external_probe_connector pins 1..4
    output logic      [3:0]  event_fire,    // action pulse per event point
    output logic             break_req      // break request pulse
);

    localparam int N = `EV_NUM;

    // configuration per event point
    logic [12:0]          cfg_q   [N];  // enable, invert, arm and reset masks, break
    logic [`EV_CNT_W-1:0] pass_q  [N];  // required occurrences
    logic [`EV_CNT_W-1:0] count_q [N];  // occurrences so far
    logic [N-1:0]         sat_q;        // satisfied state
    // trigger channels
    logic [31:0]          taddr_q [N];  // channel address
    logic [N-1:0]         ten_q;        // channel enables
    // delay
    logic [`EV_CNT_W-1:0] delay_q;      // break delay length
    logic [1:0]           owner_q;      // event point owning the delay
    // run state
    logic                 running;      // filtered run level
    // combinational sequencing
    logic [N-1:0]         hit;          // counted occurrence
    logic [N-1:0]         rise;         // entry into satisfied
    logic [N-1:0]         reset_hit;    // reset request per target
    logic                 dly_busy;     // delay counter active
    logic                 dly_done;     // delay expired
    logic                 dly_load;     // start delay
    logic                 direct_brk;   // break with no delay

    // arming check: no sources means always armed
    function automatic logic arm_ok(input logic [3:0] mask, input logic inv, input logic [3:0] sat);
        logic r;
        r = 1'b1;
        if (mask != 4'h0) begin
            // a single polarity per point: all sources judged the same way
            r = inv ? |(mask & ~sat) : |(mask & sat); // RQ5 RQ6 RQ7
        end
        return r;
    endfunction

    // event point register index from a byte offset
    function automatic logic [1:0] ep_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - `OFS_EP_BASE;
        return d[5:4];
    endfunction

    // offset within an event point window
    function automatic logic [3:0] ep_field(input logic [7:0] a);
        return a[3:0];
    endfunction

    // window tests
    function automatic logic in_ep(input logic [7:0] a);
        return (a >= `OFS_EP_BASE) && (a < `OFS_TRIG_BASE);
    endfunction

    function automatic logic in_trig(input logic [7:0] a);
        return (a >= `OFS_TRIG_BASE) && (a < 8'h70) && (a[1:0] == 2'b00);
    endfunction

    // run pin synchroniser
    run_sync u_run_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (user_run_pin),
        .level (running)
    );

    // occurrence, satisfaction entry and reset fan-in
    always_comb begin
        hit       = '0;
        rise      = '0;
        reset_hit = '0;
        for (int i = 0; i < N; i++) begin
            // disabled point keeps its settings but never counts
            if (running && bus_cycle && cfg_q[i][`CFG_ENABLE] && event_match[i] && !sat_q[i] // RQ15 RQ19
                && arm_ok(cfg_q[i][`CFG_ARM_LSB +: 4], cfg_q[i][`CFG_ARM_INV], sat_q)) begin
                hit[i] = 1'b1;
            end
            // pass count of zero or one means the first occurrence
            if (hit[i] && ((count_q[i] + 16'h0001) >= pass_q[i])) begin // RQ17
                rise[i] = 1'b1; // RQ3
            end
        end
        // reset sources act on entry only, ored per target
        for (int t = 0; t < N; t++) begin
            for (int s = 0; s < N; s++) begin
                if (rise[s] && cfg_q[t][`CFG_RST_LSB + s]) begin // RQ8 RQ10 RQ11
                    reset_hit[t] = 1'b1;
                end
            end
        end
    end

    // satisfied state per event point
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sat_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!running) begin
                    // stopped or not yet started: all unsatisfied
                    sat_q[i] <= 1'b0; // RQ1 RQ4
                end else if (reset_hit[i]) begin
                    // reset beats a simultaneous entry, incl. self reset
                    sat_q[i] <= 1'b0; // RQ9
                end else if (rise[i]) begin
                    sat_q[i] <= 1'b1; // RQ2
                end
            end
        end
    end

    // pass counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                count_q[i] <= `RST_PASS;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!running || reset_hit[i] || rise[i]) begin
                    count_q[i] <= `RST_PASS; // RQ9
                end else if (hit[i]) begin
                    count_q[i] <= count_q[i] + 16'h0001; // RQ17
                end
            end
        end
    end

    // action pulses on entry into satisfied
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_fire <= '0;
        end else begin
            event_fire <= rise; // RQ3
        end
    end

    // break routing: only the owner point may use the delay
    always_comb begin
        dly_load   = 1'b0;
        direct_brk = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (rise[i] && cfg_q[i][`CFG_BREAK]) begin
                if ((owner_q == 2'(i)) && (delay_q != 16'h0000)) begin
                    dly_load = 1'b1; // RQ18
                end else begin
                    direct_brk = 1'b1;
                end
            end
        end
    end

    break_delay u_break_delay (
        .clk    (clk),
        .rst_n  (rst_n),
        .abort  (!running),
        .load   (dly_load),
        .length (delay_q),
        .tick   (bus_cycle),
        .busy   (dly_busy),
        .done   (dly_done)
    );

    // break request pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            break_req <= 1'b0;
        end else begin
            break_req <= running && (direct_brk || dly_done); // RQ18
        end
    end

    // trigger pins high the cycle after a matching read or write access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_out <= '0;
        end else begin
            for (int c = 0; c < N; c++) begin
                // disabled channel never drives high
                trig_out[c] <= running && bus_cycle && (bus_read || bus_write) // RQ12 RQ13
                               && ten_q[c] && (bus_addr == taddr_q[c]); // RQ14
            end
        end
    end

    // event point configuration writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                cfg_q[i]  <= `RST_CFG;
                pass_q[i] <= `RST_PASS;
            end
        end else if (reg_wr && in_ep(reg_addr)) begin
            case (ep_field(reg_addr))
                `OFS_EP_CFG: begin
                    cfg_q[ep_index(reg_addr)] <= reg_wdata[12:0];
                end
                `OFS_EP_PASS: begin
                    pass_q[ep_index(reg_addr)] <= reg_wdata[15:0];
                end
                default: begin
                    // count word is read only
                end
            endcase
        end
    end

    // trigger channel addresses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < N; c++) begin
                taddr_q[c] <= `RST_TRIG_ADDR;
            end
        end else if (reg_wr && in_trig(reg_addr)) begin
            taddr_q[reg_addr[3:2]] <= reg_wdata;
        end
    end

    // trigger enables; clear-all wins over a same-cycle enable write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ten_q <= '0;
        end else if (reg_wr && (reg_addr == `OFS_CTRL) && reg_wdata[`CTRL_CLR_TRIG]) begin
            ten_q <= '0; // RQ16
        end else if (reg_wr && (reg_addr == `OFS_TRIG_EN)) begin
            ten_q <= reg_wdata[3:0]; // RQ14
        end
    end

    // delay length and owner
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_q <= `RST_DELAY;
            owner_q <= 2'h0;
        end else if (reg_wr && (reg_addr == `OFS_DELAY)) begin
            delay_q <= reg_wdata[15:0];
            owner_q <= reg_wdata[`DELAY_OWNER_LSB +: 2];
        end
    end

    // read data, registered; unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h00000000;
            if (reg_addr == `OFS_TRIG_EN) begin
                reg_rdata <= {28'h0000000, ten_q};
            end else if (reg_addr == `OFS_STATUS) begin
                reg_rdata <= {26'h0, dly_busy, running, sat_q};
            end else if (reg_addr == `OFS_DELAY) begin
                reg_rdata <= {14'h0, owner_q, delay_q};
            end else if (in_trig(reg_addr)) begin
                reg_rdata <= taddr_q[reg_addr[3:2]];
            end else if (in_ep(reg_addr)) begin
                case (ep_field(reg_addr))
                    `OFS_EP_CFG: begin
                        reg_rdata <= {19'h0, cfg_q[ep_index(reg_addr)]};
                    end
                    `OFS_EP_PASS: begin
                        reg_rdata <= {16'h0000, pass_q[ep_index(reg_addr)]};
                    end
                    `OFS_EP_COUNT: begin
                        reg_rdata <= {16'h0000, count_q[ep_index(reg_addr)]};
                    end
                    default: begin
                        reg_rdata <= 32'h00000000;
                    end
                endcase
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // event_sequencer_trigger_out

/* pkg/evseq_defines.svh */
// constants of the event sequencer and trigger output block
// assumes a 32-bit register port with byte offsets and four event points
// Functional notes
// RQ1: evaluation starts at run, all unsatisfied
// RQ2: satisfied holds until stop or reset
// RQ3: satisfied point never fires again
// RQ4: program stop clears every point together
// RQ5: arming sources gate satisfaction
// RQ6: inverted arming only on arm relations
// RQ7: one arm polarity per event point
// RQ8: satisfied point resets any chosen points
// RQ9: reset clears state and pass count
// RQ10: reset only on entry into satisfied
// RQ11: several reset sources combine as OR
// RQ12: four trigger channels with own address
// RQ13: matching access drives trigger pin high
// RQ14: per-channel enable gates trigger output
// RQ15: disabled point keeps config, no event
// RQ16: clear-all command disables all triggers
// RQ17: sixteen-bit pass count per point
// RQ18: one sixteen-bit break delay counter
// RQ19: relations evaluated once per bus cycle
`ifndef EVSEQ_DEFINES_SVH
`define EVSEQ_DEFINES_SVH

`define EV_NUM          4
`define EV_CNT_W        16
// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_TRIG_EN     8'h04
`define OFS_STATUS      8'h08
`define OFS_DELAY       8'h0C
`define OFS_EP_BASE     8'h20
`define OFS_EP_STRIDE   8'h10
`define OFS_EP_CFG      4'h0
`define OFS_EP_PASS     4'h4
`define OFS_EP_COUNT    4'h8
`define OFS_TRIG_BASE   8'h60
// field positions
`define CTRL_CLR_TRIG   0
`define CFG_ENABLE      0
`define CFG_ARM_INV     1
`define CFG_ARM_LSB     4
`define CFG_RST_LSB     8
`define CFG_BREAK       12
`define DELAY_OWNER_LSB 16
`define STAT_RUN        4
`define STAT_DELAY      5
// reset values
`define RST_CFG         13'h0000
`define RST_PASS        16'h0000
`define RST_DELAY       16'h0000
`define RST_TRIG_ADDR   32'h00000000

`endif

/* pkg/evseq_pkg.sv */
// types shared by the event sequencer files
// assumes the constants header is included by each user
package evseq_pkg;

    // break delay counter states, gray along idle -> count
    typedef enum logic [1:0] {
        DLY_IDLE  = 2'b00,
        DLY_COUNT = 2'b01
    } delay_state_type;

endpackage

/* verilog/run_sync.sv */
// three-flop synchroniser with agreement filter for the run pin
// assumes a level from outside the clock domain
`timescale 1ns/10ps
module run_sync (
    input  wire logic clk,      // system clock
    input  wire logic rst_n,    // async reset, active low
    input  wire logic pin,      // raw level from outside
    output logic      level     // filtered level
);

    logic s1_q;  // first stage, read only by s2
    logic s2_q;  // second stage
    logic s3_q;  // third stage

    // shift chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once two late stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end

endmodule // run_sync

/* verilog/break_delay.sv */
// single break delay counter, counts monitored bus cycles
// assumes load and tick come from logic on the same clock
`timescale 1ns/10ps
`include "evseq_defines.svh"
module break_delay (
    input  wire logic                 clk,      // system clock
    input  wire logic                 rst_n,    // async reset, active low
    input  wire logic                 abort,    // program stopped
    input  wire logic                 load,     // start a delay
    input  wire logic [`EV_CNT_W-1:0] length,   // bus cycles to wait
    input  wire logic                 tick,     // one bus cycle passed
    output logic                      busy,     // counting
    output logic                      done      // one-cycle expiry pulse
);

    evseq_pkg::delay_state_type state_q;  // counter state
    logic [`EV_CNT_W-1:0]       cnt_q;    // cycles left

    assign busy = (state_q == evseq_pkg::DLY_COUNT);

    // countdown; a second load while busy is ignored, only one owner exists
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= evseq_pkg::DLY_IDLE;
            cnt_q   <= `RST_DELAY;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_q)
                evseq_pkg::DLY_IDLE: begin
                    if (load && !abort) begin
                        cnt_q   <= length;
                        state_q <= evseq_pkg::DLY_COUNT;
                    end
                end
                evseq_pkg::DLY_COUNT: begin
                    if (abort) begin
                        state_q <= evseq_pkg::DLY_IDLE;
                    end else if (tick) begin
                        if (cnt_q <= 16'h0001) begin
                            done    <= 1'b1;
                            state_q <= evseq_pkg::DLY_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                end
                default: begin
                    state_q <= evseq_pkg::DLY_IDLE;
                end
            endcase
        end
    end

endmodule // break_delay

/* tb/evseq_properties.sv */
// port-level checker for the event sequencer and trigger outputs
// assumes one clock and an async active-low reset, bound below
`timescale 1ns/10ps
`include "evseq_defines.svh"
module evseq_properties (
    input wire logic        clk,          // system clock
    input wire logic        rst_n,        // async reset, active low
    input wire logic [7:0]  reg_addr,     // register offset
    input wire logic [31:0] reg_wdata,    // write data
    input wire logic        reg_wr,       // write strobe
    input wire logic        reg_rd,       // read strobe
    input wire logic [31:0] reg_rdata,    // read data
    input wire logic        user_run_pin, // run level, raw
    input wire logic        bus_cycle,    // monitored cycle
    input wire logic        bus_read,     // read access
    input wire logic        bus_write,    // write access
    input wire logic [3:0]  event_match,  // comparator hits
    input wire logic [3:0]  trig_out,     // trigger pins
    input wire logic [3:0]  event_fire,   // action pulses
    input wire logic        break_req     // break pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [3:0] en_q; // mirror of trigger enables

    // mirror enables, clear-all wins as in the design
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            en_q <= 4'h0;
        else if (reg_wr && reg_addr == `OFS_CTRL && reg_wdata[`CTRL_CLR_TRIG])
            en_q <= 4'h0;
        else if (reg_wr && reg_addr == `OFS_TRIG_EN)
            en_q <= reg_wdata[3:0];
    end

    a_reset_clean: assert property ($rose(rst_n) |-> {trig_out, event_fire, break_req} == 9'h000)
        else $error("outputs not quiet after reset");
    a_fire_cause: assert property ((event_fire & ~$past(event_match & {4{bus_cycle}})) == 4'h0)
        else $error("fire without matching bus cycle");
    a_trig_cause: assert property (|trig_out |-> $past(bus_cycle && (bus_read || bus_write)))
        else $error("trigger without access");
    a_trig_single: assert property (|trig_out && !bus_cycle |=> trig_out == 4'h0)
        else $error("trigger longer than access");
    a_trig_enable: assert property ((trig_out & ~$past(en_q)) == 4'h0)
        else $error("disabled trigger asserted");
    a_clear_trig: assert property (reg_wr && reg_addr == `OFS_CTRL && reg_wdata[0] |-> ##2 trig_out == 4'h0)
        else $error("trigger after clear-all");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_stop_quiet: assert property (!user_run_pin [*7] |-> event_fire == 4'h0 && trig_out == 4'h0 && !break_req)
        else $error("activity while stopped");

    c_fire: cover property (|event_fire);
    c_break: cover property (break_req);
    c_trig: cover property (|trig_out);
endmodule // evseq_properties

bind event_sequencer_trigger_out evseq_properties chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .user_run_pin(user_run_pin),
    .bus_cycle(bus_cycle), .bus_read(bus_read), .bus_write(bus_write), .event_match(event_match),
    .trig_out(trig_out), .event_fire(event_fire), .break_req(break_req));

/* tb/target_bus_model.sv */
// monitored target bus: one cycle per request, inverted last values otherwise
// assumes requests come from the bench on the same clock
`timescale 1ns/10ps
module target_bus_model (
    input  wire logic        clk,         // system clock
    input  wire logic        rst_n,       // async reset, active low
    input  wire logic        req,         // issue a bus cycle now
    input  wire logic [31:0] a,           // access address
    input  wire logic        rd,          // read access
    input  wire logic        wr,          // write access
    input  wire logic [3:0]  m,           // comparator hits
    output logic             bus_cycle,   // cycle strobe
    output logic      [31:0] bus_addr,    // address lines
    output logic             bus_read,    // read line
    output logic             bus_write,   // write line
    output logic      [3:0]  event_match  // hit lines
);
    logic [37:0] last_q; // last driven lines

    // idle lines show the inverse, so stale values are never trusted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            last_q <= 38'h0;
        else if (req)
            last_q <= {m, rd, wr, a};
    end

    assign bus_cycle = req;
    assign {event_match, bus_read, bus_write, bus_addr} = req ? {m, rd, wr, a} : ~last_q;
endmodule // target_bus_model

/* tb/testbench.sv */
// random and directed tests of the event sequencer with a reference model
// assumes the design, the bus model and the bound checker are compiled
`timescale 1ns/10ps
`include "evseq_defines.svh"
module testbench;
    localparam int LIMIT = 12000; // cycles before the watchdog
    logic        clk, rst_n, reg_wr, reg_rd, user_run_pin, req, rd, wr;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, a, bus_addr;
    logic [3:0]  m, event_match, trig_out, event_fire;
    logic        bus_cycle, bus_read, bus_write, break_req;
    int          n_mismatch, n_checks, dcnt, dlen, cnt [4];
    logic [31:0] seed, taddr [4];
    logic [12:0] cfg [4];
    logic [15:0] pass [4];
    logic [3:0]  sat, ten, exp_fire, exp_trig;
    logic        run, exp_brk, dly;
    localparam logic [12:0] DCFG [4] = '{13'h1001, 13'h0011, 13'h0013, 13'h0B01}; // corner table

    event_sequencer_trigger_out uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .user_run_pin(user_run_pin), .bus_cycle(bus_cycle), .bus_addr(bus_addr),
        .bus_read(bus_read), .bus_write(bus_write), .event_match(event_match),
        .trig_out(trig_out), .event_fire(event_fire), .break_req(break_req));
    target_bus_model far (.clk(clk), .rst_n(rst_n), .req(req), .a(a), .rd(rd), .wr(wr), .m(m),
        .bus_cycle(bus_cycle), .bus_addr(bus_addr), .bus_read(bus_read), .bus_write(bus_write),
        .event_match(event_match));

    // free-running clock, 50 ns
    always #25 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus cycle of the reference model on the inputs now applied
    task automatic modl();
        logic [3:0] f;
        logic       busy;
        f = 4'h0;
        busy = dcnt > 0;
        exp_trig = 4'h0;
        exp_brk = dly && run; // expiry pulse is registered once more on its way out
        dly = 1'h0;
        if (req && run) begin
            if (dcnt > 0) begin
                dcnt--;
                dly = (dcnt == 0);
            end
            for (int i = 0; i < 4; i++) begin
                if (cfg[i][0] && m[i] && !sat[i] && (cfg[i][7:4] == 4'h0 ||
                    |(cfg[i][7:4] & (cfg[i][1] ? ~sat : sat)))) begin
                    cnt[i]++;
                    f[i] = cnt[i] >= ((pass[i] > 0) ? pass[i] : 1);
                end
                exp_trig[i] = (rd || wr) && a == taddr[i] && ten[i];
            end
            for (int i = 0; i < 4; i++) begin
                if (f[i] && cfg[i][12] && i == 0 && dlen > 0)
                    dcnt = busy ? dcnt : dlen; // a load while counting is ignored
                else if (f[i] && cfg[i][12])
                    exp_brk = 1'h1;
                if (f[i])
                    cnt[i] = 0;
                if (f[i])
                    sat[i] = 1'h1;
                if (|(cfg[i][11:8] & f)) begin
                    sat[i] = 1'h0;
                    cnt[i] = 0;
                end
            end
        end
        exp_fire = f;
    endtask

    // check last cycle's pulses, then apply the next bus request
    task automatic cyc(logic b, logic [31:0] ad, logic r, logic w, logic [3:0] mm);
        @(posedge clk);
        chk("event_fire", exp_fire, event_fire);
        chk("trig_out", exp_trig, trig_out);
        chk("break_req", exp_brk, break_req);
        modl();
        req <= b;
        a <= ad;
        rd <= r;
        wr <= w;
        m <= mm;
    endtask

    task automatic wreg(logic [7:0] ad, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rreg(logic [7:0] ad, logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(posedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask

    // move the run pin and wait out the synchroniser
    task automatic go(logic r);
        user_run_pin <= r;
        repeat (8) cyc(1'h0, 32'h0, 1'h0, 1'h0, 4'h0);
        run = r;
        sat = r ? sat : 4'h0;
        dcnt = r ? dcnt : 0;
        cnt = '{default: 0};
    endtask

    // watchdog sized from the expected run length
    initial begin
        #(50 * LIMIT);
        n_mismatch++;
        print_verdict();
    end

    // main sequence
    initial begin
        logic [7:0] ep;
        logic       r;
        clk = 1'h0;
        rst_n = 1'h0;
        {reg_wr, reg_rd, user_run_pin, req, rd, wr, run, exp_brk, dly} = 9'h000;
        {reg_addr, reg_wdata, a, m, sat, ten, exp_fire, exp_trig} = 92'h0;
        {n_mismatch, n_checks, dcnt, dlen} = 128'h0;
        cnt = '{default: 0};
        seed = 32'h5A2B2A75;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        rreg(`OFS_EP_BASE, 32'h0);
        rreg(`OFS_TRIG_EN, 32'h0);
        rreg(`OFS_DELAY, 32'h0);
        wreg(`OFS_STATUS, 32'hFFFFFFFF);
        rreg(`OFS_STATUS, 32'h0);
        wreg(8'hF0, 32'hFFFFFFFF);
        rreg(8'hF0, 32'h0);
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 4; i++) begin
                ep = 8'(`OFS_EP_BASE + `OFS_EP_STRIDE * i);
                cfg[i] = (k == 0) ? DCFG[i] : (13'($random(seed)) & 13'h1FF3) | 13'(k & 1);
                pass[i] = (k == 0 && i == 1) ? 16'h0002 : 16'($random(seed) & 3);
                taddr[i] = $random(seed);
                wreg(ep, 32'(cfg[i]));
                wreg(ep + `OFS_EP_PASS, 32'(pass[i]));
                wreg(8'(`OFS_TRIG_BASE + 4 * i), taddr[i]);
            end
            dlen = (k == 0) ? 3 : 0;
            wreg(`OFS_DELAY, 32'(dlen));
            ten = $random(seed);
            wreg(`OFS_TRIG_EN, 32'(ten));
            if (k % 3 == 2) begin
                wreg(`OFS_CTRL, 32'h1);
                ten = 4'h0;
            end
            go(1'h1);
            rreg(`OFS_STATUS, 32'h10);
            for (int j = 0; j < 150; j++) begin
                r = $random(seed);
                cyc(($random(seed) & 3) != 0, ($random(seed) & 1) ? taddr[$random(seed) & 3] : $random(seed),
                    r, !r && ($random(seed) & 1), $random(seed));
            end
            repeat (2) cyc(1'h0, 32'h0, 1'h0, 1'h0, 4'h0);
            for (int i = 0; i < 4; i++) begin
                rreg(8'(`OFS_EP_BASE + `OFS_EP_STRIDE * i), 32'(cfg[i]));
                rreg(8'(`OFS_EP_BASE + `OFS_EP_STRIDE * i + `OFS_EP_COUNT), 32'(cnt[i]));
            end
            rreg(`OFS_STATUS, {26'h0, dcnt != 0, 1'h1, sat});
            go(1'h0);
            rreg(`OFS_STATUS, 32'h0);
            $display("round %0d done", k);
        end
        print_verdict();
    end
endmodule // testbench
